//--- tws_pkg.sv
// package: constants and carrier types of the two-wire eeprom slave
// How it works
// (RULE_01) capture data on clock rise, change on fall
// (RULE_02) data line only pulled low or released
// (RULE_03) answer only when select bits match pins
// (RULE_04) floating select pins read as low
// (RULE_05) write-protect low lets writes proceed
// (RULE_06) write-protect high blocks all array writes
// (RULE_07) floating write-protect reads low, writes enabled
// (RULE_08) 512 pages of 128 bytes, page from top
// (RULE_09) random access carries a 16-bit word address
// (RULE_10) page writes of 1 to 128 bytes
// (RULE_11) self-timed programming cycle, at most 5 ms
// (RULE_12) host keeps clock at or below 1 MHz
// (RULE_13) address word starts with fixed four-bit code
// (RULE_14) last address bit high reads, low writes
// (RULE_15) acknowledge every received byte on ninth clock
// (RULE_16) start and stop framed by data while clock high
// (RULE_17) page byte address increments, wraps inside page
// (RULE_18) ignore bus and withhold ack while programming
package tws_pkg;
    localparam int unsigned CLK_SYS_MHZ = 125;           // system clock rate
    localparam int unsigned T_WR_MS     = 5;             // longest programming time
    localparam int unsigned T_WR_CYC    = T_WR_MS * 1000 * CLK_SYS_MHZ; // exact product, no rounding
    localparam int unsigned PAGE_BYTES  = 128;
    localparam int unsigned PAGE_COUNT  = 512;
    localparam int unsigned ADDR_W      = 16;
    localparam logic [3:0]  DEV_CODE    = 4'ha;          // fixed 1010 pattern
    localparam logic [3:0]  BIT_PRE_ACK = 4'h7;          // select bits complete
    localparam logic [3:0]  BIT_LAST    = 4'h8;          // byte complete
    localparam logic [3:0]  BIT_ACK     = 4'h9;          // acknowledge clock
    localparam logic [3:0]  TX_BASE     = 4'h6;          // bit index offset while sending
    localparam logic [6:0]  SYNC_RST    = 7'h60;         // scl, sda high; toggle, wp, select low
    localparam logic [15:0] ADDR_RST    = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE, ST_DEV, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA, ST_RDATA, ST_IGNORE
    } tws_state_t;

    // level to drive in the clock period after the falling edge that follows the next rising edge
    typedef struct packed {
        logic drive;      // pull the data line low
        logic after_ack;  // cancel if the host sends no-acknowledge
    } tws_drv_t;
endpackage

//--- tws_eeprom.sv
// two-wire eeprom slave: pin capture, protocol, page buffer and array
`timescale 1ns/10ps
module tws_eeprom
    import tws_pkg::*;
#(
    parameter int unsigned T_WR_CYCLES  = T_WR_CYC,
    parameter int unsigned PAGE_BYTES_P = PAGE_BYTES,
    parameter int unsigned PAGE_COUNT_P = PAGE_COUNT
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       clk_scl_i,
    input  wire logic       sda_i,
    input  wire logic [2:0] device_select_pins_i,
    input  wire logic       wp_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic            busy_o
);
    localparam int unsigned MEM_BYTES = PAGE_BYTES_P * PAGE_COUNT_P;
    localparam int unsigned IDX_W     = $clog2(PAGE_BYTES_P);
    localparam int unsigned BW        = $clog2(T_WR_CYCLES + 1);

    // the protocol addresses exactly 64 KiB and commits the page inside the timed cycle
    if (MEM_BYTES != (1 << ADDR_W) || (1 << IDX_W) != PAGE_BYTES_P || T_WR_CYCLES < PAGE_BYTES_P) begin : g_chk
        $error("tws_eeprom: unsupported page or timing parameters");
    end

    // ---------------- link domain, clocked by scl ----------------
    tws_drv_t drv_req_ff;
    logic     bit_ff;
    logic     tgl_ff;
    logic     req_meta_ff;
    logic     sda_oe_ff;
    logic     sda_out_ff;

    // link clock stops between frames, so this domain resets without it
    always_ff @(posedge clk_scl_i or posedge rst_i) begin
        if (rst_i) begin
            bit_ff      <= 1'b1;
            tgl_ff      <= 1'b0;
            req_meta_ff <= 1'b0;
        end else begin
            bit_ff      <= sda_i;                  // [RULE_01]
            tgl_ff      <= ~tgl_ff;                // one toggle per received bit
            req_meta_ff <= drv_req_ff.drive & ~(drv_req_ff.after_ack & sda_i); // no-ack cancels next byte
        end
    end

    // outgoing level changes only on the falling edge
    always_ff @(negedge clk_scl_i or posedge rst_i) begin
        if (rst_i) begin
            sda_oe_ff  <= 1'b0;
            sda_out_ff <= 1'b0;
        end else begin
            sda_oe_ff  <= req_meta_ff;             // [RULE_01]
            sda_out_ff <= 1'b0;                    // only ever pulls low [RULE_02]
        end
    end

    assign sda_oe_o = sda_oe_ff;
    assign sda_o    = sda_out_ff;

    // ---------------- pin synchronisers, system domain ----------------
    logic [6:0] sync1_ff;
    logic [6:0] sync2_ff;
    logic [6:0] sync3_ff;
    logic [6:0] lvl_ff;
    logic [6:0] lvl_q_ff;
    wire  [6:0] in_raw = {clk_scl_i, sda_i, tgl_ff, wp_i, device_select_pins_i};
    wire  [6:0] agree  = ~(sync2_ff ^ sync3_ff);

    // a level moves only once the second and third stages agree
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sync1_ff <= SYNC_RST;
            sync2_ff <= SYNC_RST;
            sync3_ff <= SYNC_RST;
            lvl_ff   <= SYNC_RST;                  // select and wp start low [RULE_04] [RULE_07]
            lvl_q_ff <= SYNC_RST;
        end else begin
            sync1_ff <= in_raw;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            lvl_ff   <= (sync3_ff & agree) | (lvl_ff & ~agree);
            lvl_q_ff <= lvl_ff;
        end
    end

    // pad pull-downs turn floating select and wp pins into zeros before they arrive here
    wire       scl_lvl = lvl_ff[6];
    wire       sda_lvl = lvl_ff[5];
    wire       wp_lvl  = lvl_ff[3];                // [RULE_07]
    wire [2:0] sel_lvl = lvl_ff[2:0];              // [RULE_04]
    wire       start_ev = scl_lvl & lvl_q_ff[6] & lvl_q_ff[5] & ~sda_lvl; // [RULE_16]
    wire       stop_ev  = scl_lvl & lvl_q_ff[6] & ~lvl_q_ff[5] & sda_lvl; // [RULE_16]
    wire       bit_ev   = lvl_ff[4] ^ lvl_q_ff[4];

    // ---------------- protocol state ----------------
    tws_state_t      state_ff;
    logic [3:0]      cnt_ff;
    logic [7:0]      shift_ff;
    logic [7:0]      tx_ff;
    logic [15:0]     addr_ff;
    logic            wr_pend_ff;
    logic            busy_ff;
    logic [BW-1:0]   busy_cnt_ff;
    logic [PAGE_BYTES_P-1:0] mask_ff;
    logic [7:0]      page_buf [0:PAGE_BYTES_P-1];
    logic [7:0]      mem      [0:MEM_BYTES-1];

    tws_state_t      nxt_state;
    tws_drv_t        nxt_drv;
    logic [3:0]      nxt_cnt;
    logic [7:0]      nxt_tx;
    logic [15:0]     nxt_addr;
    logic            nxt_wr_pend;
    logic            buf_we;
    logic            mask_clr;

    // decoding of the byte being received
    wire [3:0]       cnt_inc   = (cnt_ff == BIT_ACK) ? 4'h1 : cnt_ff + 4'h1;
    wire [7:0]       shift_nxt = {shift_ff[6:0], bit_ff};
    wire             dev_match = (shift_nxt[6:3] == DEV_CODE) & (shift_nxt[2:0] == sel_lvl); // [RULE_03] [RULE_13]
    wire [7:0]       rd_byte   = mem[addr_ff];
    wire [2:0]       tx_idx    = (cnt_inc == BIT_ACK) ? 3'h6 : 3'(TX_BASE - cnt_inc);
    wire [IDX_W-1:0] page_idx  = addr_ff[IDX_W-1:0];
    wire [IDX_W-1:0] idx_inc   = IDX_W'(page_idx + 1'b1);
    wire [15:0]      addr_inc  = addr_ff + 16'h0001;
    wire             commit_ph = busy_ff & (busy_cnt_ff < BW'(PAGE_BYTES_P));
    wire [IDX_W-1:0] commit_ix = busy_cnt_ff[IDX_W-1:0];
    wire             busy_done = busy_ff & (busy_cnt_ff == BW'(T_WR_CYCLES - 1));
    wire             wr_start  = stop_ev & wr_pend_ff & ~wp_lvl & ~busy_ff;

    // next state: start and stop outrank a bit arriving in the same cycle
    always_comb begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_drv     = drv_req_ff;
        nxt_tx      = tx_ff;
        nxt_addr    = addr_ff;
        nxt_wr_pend = wr_pend_ff;
        buf_we      = 1'b0;
        mask_clr    = 1'b0;
        if (start_ev) begin
            nxt_state   = busy_ff ? ST_IGNORE : ST_DEV;       // [RULE_18]
            nxt_cnt     = 4'h0;
            nxt_drv     = '0;
            nxt_wr_pend = 1'b0;                               // unfinished write is dropped
        end else if (stop_ev) begin
            nxt_state   = ST_IDLE;
            nxt_drv     = '0;
            nxt_wr_pend = 1'b0;
        end else if (bit_ev && state_ff != ST_IDLE) begin
            nxt_cnt = cnt_inc;
            case (state_ff)
                ST_DEV: begin
                    if (cnt_inc == BIT_PRE_ACK) begin
                        nxt_drv = '{drive: ~busy_ff & dev_match, after_ack: 1'b0}; // [RULE_03] [RULE_15]
                        if (busy_ff || !dev_match) begin
                            nxt_state = ST_IGNORE;                // [RULE_18]
                        end
                    end else if (cnt_inc == BIT_LAST) begin
                        if (shift_nxt[0]) begin                   // [RULE_14]
                            nxt_state = ST_RDATA;
                            nxt_tx    = rd_byte;
                            nxt_addr  = addr_inc;
                            nxt_drv   = '{drive: ~rd_byte[7], after_ack: 1'b0};
                        end else begin
                            nxt_state = ST_ADDR_HI;
                            nxt_drv   = '0;
                        end
                    end
                end
                ST_ADDR_HI, ST_ADDR_LO, ST_WDATA: begin
                    if (cnt_inc == BIT_PRE_ACK) begin
                        nxt_drv = '{drive: 1'b1, after_ack: 1'b0};   // [RULE_15]
                    end else if (cnt_inc == BIT_LAST) begin
                        nxt_drv = '0;
                        if (state_ff == ST_ADDR_HI) begin
                            nxt_addr  = {shift_nxt, addr_ff[7:0]};  // [RULE_09]
                            nxt_state = ST_ADDR_LO;
                        end else if (state_ff == ST_ADDR_LO) begin
                            nxt_addr  = {addr_ff[15:8], shift_nxt}; // [RULE_09]
                            nxt_state = ST_WDATA;
                            mask_clr  = 1'b1;
                        end else begin
                            buf_we      = 1'b1;                     // [RULE_10]
                            nxt_wr_pend = 1'b1;
                            nxt_addr    = {addr_ff[15:IDX_W], idx_inc}; // [RULE_17]
                        end
                    end
                end
                ST_RDATA: begin
                    if (cnt_inc == BIT_PRE_ACK) begin
                        nxt_drv = '0;                             // host acknowledges on clock nine
                    end else if (cnt_inc == BIT_LAST) begin
                        nxt_tx   = rd_byte;
                        nxt_addr = addr_inc;
                        nxt_drv  = '{drive: ~rd_byte[7], after_ack: 1'b1};
                    end else if (cnt_inc == BIT_ACK && bit_ff) begin
                        nxt_state = ST_IGNORE;                    // no-ack ends the read
                        nxt_drv   = '0;
                    end else begin
                        nxt_drv = '{drive: ~tx_ff[tx_idx], after_ack: 1'b0};
                    end
                end
                ST_IGNORE: begin
                    nxt_drv = '0;
                end
                default: begin
                    nxt_state = ST_IDLE;
                    nxt_drv   = '0;
                end
            endcase
        end
    end

    // protocol registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_ff   <= ST_IDLE;
            cnt_ff     <= 4'h0;
            shift_ff   <= 8'h00;
            tx_ff      <= 8'h00;
            addr_ff    <= ADDR_RST;
            wr_pend_ff <= 1'b0;
            drv_req_ff <= '0;
        end else begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            shift_ff   <= bit_ev ? shift_nxt : shift_ff;
            tx_ff      <= nxt_tx;
            addr_ff    <= nxt_addr;
            wr_pend_ff <= nxt_wr_pend;
            drv_req_ff <= nxt_drv;
        end
    end

    // programming cycle: starts at stop only when wp is low
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            busy_ff     <= 1'b0;
            busy_cnt_ff <= '0;
        end else if (wr_start) begin
            busy_ff     <= 1'b1;                   // [RULE_05] [RULE_06] [RULE_11]
            busy_cnt_ff <= '0;
        end else if (busy_done) begin
            busy_ff     <= 1'b0;                   // [RULE_11]
            busy_cnt_ff <= '0;
        end else if (busy_ff) begin
            busy_cnt_ff <= busy_cnt_ff + 1'b1;
        end
    end
    assign busy_o = busy_ff;

    // byte mask of the page buffer; cleared when a new write addresses the array
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || mask_clr) begin
            mask_ff <= '0;
        end else if (buf_we) begin
            mask_ff[page_idx] <= 1'b1;             // partial pages keep untouched bytes [RULE_10]
        end
    end

    // page buffer; costs a page of storage but keeps the array intact until stop
    always_ff @(posedge clk_sys_i) begin
        if (buf_we) begin
            page_buf[page_idx] <= shift_nxt;
        end
    end

    // array: one buffered byte per cycle during the first cycles of programming
    always_ff @(posedge clk_sys_i) begin
        if (commit_ph && mask_ff[commit_ix]) begin
            mem[{addr_ff[15:IDX_W], commit_ix}] <= page_buf[commit_ix]; // page from top bits [RULE_08]
        end
    end

    // ---------------- assertions ----------------
    logic [BW:0] hlp_busy_len_ff;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            hlp_busy_len_ff <= '0;
        end else begin
            hlp_busy_len_ff <= busy_ff ? hlp_busy_len_ff + 1'b1 : '0;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_busy_no_ack: assert property (busy_ff && start_ev |=> state_ff == ST_IGNORE && !drv_req_ff.drive) // [RULE_18]
        else $error("acknowledge requested while programming");
    a_busy_length: assert property ($fell(busy_ff) |-> hlp_busy_len_ff == (BW + 1)'(T_WR_CYCLES)) // [RULE_11]
        else $error("programming cycle length wrong");
    a_wp_blocks: assert property (stop_ev && wr_pend_ff && wp_lvl && !busy_ff |=> !busy_ff [*3]) // [RULE_06]
        else $error("write started while protected");
    a_wp_low_writes: assert property (stop_ev && wr_pend_ff && !wp_lvl && !busy_ff |=> busy_ff) // [RULE_05]
        else $error("write not started at stop");
    a_sel_ack: assert property (state_ff == ST_DEV && !busy_ff && bit_ev && !start_ev && !stop_ev // [RULE_03]
        && cnt_inc == BIT_PRE_ACK |=> drv_req_ff.drive == $past(dev_match))
        else $error("select match and acknowledge disagree");
    // the release must follow within one slow bus clock, well inside the bound
    a_data_ack: assert property (state_ff == ST_WDATA && bit_ev && !start_ev && !stop_ev // [RULE_15]
        && cnt_inc == BIT_PRE_ACK |=> drv_req_ff.drive ##[1:1000] !drv_req_ff.drive)
        else $error("data byte not acknowledged");
    a_page_wrap: assert property (buf_we && page_idx == IDX_W'(PAGE_BYTES_P - 1) // [RULE_17]
        |=> addr_ff[IDX_W-1:0] == '0 && addr_ff[15:IDX_W] == $past(addr_ff[15:IDX_W]))
        else $error("page address did not wrap in page");
    a_start_frame: assert property (start_ev && !busy_ff |=> state_ff == ST_DEV && cnt_ff == 4'h0) // [RULE_16]
        else $error("start did not open a new frame");
    a_word_addr: assert property (state_ff == ST_ADDR_LO && bit_ev && !start_ev && !stop_ev // [RULE_09]
        && cnt_inc == BIT_LAST |=> addr_ff == {$past(addr_ff[15:8]), $past(shift_nxt)})
        else $error("word address not assembled");

    c_write_commit: cover property ($rose(busy_ff));
    c_read_byte:    cover property (state_ff == ST_RDATA && bit_ev && cnt_inc == BIT_LAST);
    c_wp_blocked:   cover property (stop_ev && wr_pend_ff && wp_lvl);
    c_sel_miss:     cover property (state_ff == ST_DEV && bit_ev && cnt_inc == BIT_PRE_ACK && !dev_match);
endmodule

//--- tws_host.sv
// two-wire host model: drives the bus clock and its open-drain pull on the data wire
`timescale 1ns/10ps
module tws_host #(
    parameter int unsigned HALF_TICKS = 4                // 4 x 160 ns per phase keeps the bus near 781 kHz
) (
    input  wire logic sda_i,                            // resolved data wire
    output logic      scl_o,
    output logic      sda_low_o                          // high while the host pulls data low
);
    logic tick_clk;

    // 160 ns reference, offset so its edges never line up with the system clock
    initial begin
        tick_clk = 1'b0;
        #37;
        forever #80 tick_clk = ~tick_clk;
    end

    // clock stands still high and data is released outside frames
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge tick_clk);
    endtask

    // start, or repeated start when the clock is low: data falls while clock high
    task automatic start();
        if (!scl_o) begin
            sda_low_o = 1'b0;
            wt(2);
            scl_o = 1'b1;
        end
        wt(HALF_TICKS);
        sda_low_o = 1'b1;
        wt(HALF_TICKS);
        scl_o = 1'b0;
        wt(2);
    endtask

    // stop: data rises while clock high
    task automatic stop();
        sda_low_o = 1'b1;
        wt(2);
        scl_o = 1'b1;
        wt(HALF_TICKS);
        sda_low_o = 1'b0;
        wt(HALF_TICKS);
    endtask

    // one clock: data only changes in the low phase, sampled mid high phase
    task automatic bit_io(input logic b, output logic seen);
        sda_low_o = ~b;
        wt(HALF_TICKS - 2);
        scl_o = 1'b1;
        wt(HALF_TICKS / 2);
        seen = sda_i;
        wt(HALF_TICKS / 2);
        scl_o = 1'b0;
        wt(2);
    endtask

    // byte out msb first, then release for the ninth clock and report the acknowledge
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, ack);
    endtask

    // byte in msb first; host answers 0 to continue or 1 to end the read
    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(nack, s);
    endtask
endmodule

//--- tws_eeprom_tb_top.sv
// self-checking bench of the two-wire eeprom slave with a host model on the bus
`timescale 1ns/10ps
module tws_eeprom_tb_top;
    import tws_pkg::*;
    localparam int unsigned TWR   = 3000;    // short programming cycle, still long enough for one refused frame
    localparam int unsigned PGB   = 8;       // short page so the wrap costs few bus clocks
    localparam int unsigned LIMIT = 99000;
    logic       clk_sys_i;
    logic       rst_i;
    logic       wp_i;
    logic       sda_o;
    logic       sda_oe_o;
    logic       busy_o;
    logic       scl;
    logic       host_low;
    logic       sda_wire;
    logic [2:0] pins;
    logic [2:0] sel;
    logic [7:0] exp_mem [int];
    int         error_cnt = 0;
    int         total_checks = 0;
    int         cyc = 0;
    int         busy_len = 0;
    int         last_busy = 0;

    // wire-and of both pulls with the pull-up
    assign sda_wire = ~(host_low | (sda_oe_o & ~sda_o));

    // page count scales with the short page so the array still spans the full 16-bit address
    tws_eeprom #(.T_WR_CYCLES(TWR), .PAGE_BYTES_P(PGB), .PAGE_COUNT_P(65536 / PGB)) i_dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_scl_i(scl), .sda_i(sda_wire),
        .device_select_pins_i(pins), .wp_i(wp_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .busy_o(busy_o));

    tws_host i_host (.sda_i(sda_wire), .scl_o(scl), .sda_low_o(host_low));

    initial clk_sys_i = 1'b0;
    always #4 clk_sys_i = ~clk_sys_i;

    // run ceiling and length of each busy stretch, sampled away from the launching edge
    always @(negedge clk_sys_i) begin
        cyc++;
        if (busy_o === 1'b1) busy_len++;
        else begin
            if (busy_len != 0) last_busy = busy_len;
            busy_len = 0;
        end
        if (cyc == LIMIT) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic summarize();
        if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // array slot of the i-th data byte: only the byte index advances, wrapping inside the page
    function automatic int page_slot(input logic [15:0] base, input int i);
        return int'(base) - int'(base) % PGB + (int'(base) + i) % PGB;
    endfunction

    task automatic do_write(input logic [15:0] addr, input int n);
        logic       ack;
        logic [7:0] d;
        i_host.start();
        i_host.wr_byte({DEV_CODE, sel, 1'b0}, ack);
        chk("ack dev wr", 16'(ack), 16'h0000);
        i_host.wr_byte(addr[15:8], ack);
        chk("ack addr hi", 16'(ack), 16'h0000);
        i_host.wr_byte(addr[7:0], ack);
        chk("ack addr lo", 16'(ack), 16'h0000);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            i_host.wr_byte(d, ack);
            chk("ack data", 16'(ack), 16'h0000);
            if (!wp_i) exp_mem[page_slot(addr, i)] = d;
        end
        i_host.stop();
    endtask

    task automatic do_read(input logic [15:0] addr, input int n);
        logic       ack;
        logic [7:0] d;
        i_host.start();
        i_host.wr_byte({DEV_CODE, sel, 1'b0}, ack);
        i_host.wr_byte(addr[15:8], ack);
        i_host.wr_byte(addr[7:0], ack);
        i_host.start();
        i_host.wr_byte({DEV_CODE, sel, 1'b1}, ack);
        chk("ack dev rd", 16'(ack), 16'h0000);
        for (int i = 0; i < n; i++) begin
            i_host.rd_byte(i == n - 1, d);
            chk("read data", 16'(d), 16'(exp_mem[int'(addr) + i]));
        end
        i_host.stop();
    endtask

    // address word that must not be acknowledged
    task automatic refuse(input logic [3:0] code, input logic [2:0] s);
        logic ack;
        i_host.start();
        i_host.wr_byte({code, s, 1'b0}, ack);
        chk("nack dev", 16'(ack), 16'h0001);
        i_host.stop();
    endtask

    task automatic wait_idle();
        for (int k = 0; k < 10000 && busy_o !== 1'b0; k++) @(negedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask

    // main sequence: inputs change on the falling system clock edge
    initial begin
        logic [15:0] base;
        void'($urandom(32'had9e));
        rst_i = 1'b1;
        wp_i  = 1'b0;
        sel   = 3'($urandom);
        pins  = sel;
        repeat (16) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (8) @(negedge clk_sys_i);
        chk("sda_o", 16'(sda_o), 16'h0000);
        chk("sda_oe_o idle", 16'(sda_oe_o), 16'h0000);
        // page write running past the page end, then a frame while programming
        base = 16'(($urandom & 32'h0ff8) | 32'h5);
        do_write(base, PGB + 2);
        @(negedge clk_sys_i);
        chk("busy after stop", 16'(busy_o), 16'h0001);
        refuse(DEV_CODE, sel);
        wait_idle();
        chk("busy length", 16'(last_busy), 16'(TWR));
        do_read(base & 16'hfff8, PGB);
        // wrong select bits one at a time, then a wrong fixed code
        for (int k = 0; k < 4; k++) begin
            refuse(k < 3 ? DEV_CODE : ~DEV_CODE, k < 3 ? sel ^ 3'(1 << k) : sel);
        end
        // protected write leaves the array alone and starts no programming
        @(negedge clk_sys_i);
        wp_i = 1'b1;
        do_write(base, 1);
        repeat (100) @(negedge clk_sys_i);
        chk("busy under wp", 16'(busy_o), 16'h0000);
        do_read(base, 1);
        // straps and protect driven low, the level that floating pins read as
        @(negedge clk_sys_i);
        wp_i = 1'b0;
        pins = 3'h0;
        sel  = 3'h0;
        base = 16'($urandom & 32'h0fff);
        do_write(base, 1);
        wait_idle();
        do_read(base, 1);
        summarize();
    end
endmodule
